// *** src/adc_host_pkg.sv ***
// shared constants, register map and state type of the converter host controller
package adc_host_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;

    // least times round up to whole cycles
    function automatic int ns_to_cycles(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int T_W_NS      = 300;  // joint low time of all controls to start
    localparam int T_DS_NS     = 200;  // mode lines settle before controls drop
    localparam int T_SD_NS     = 250;  // status low to valid read data
    localparam int SYNC_STAGES = 2;

    localparam int T_W_CYC  = ns_to_cycles(T_W_NS);
    localparam int T_DS_CYC = ns_to_cycles(T_DS_NS);
    localparam int T_RD_CYC = ns_to_cycles(T_SD_NS) + SYNC_STAGES;

    localparam int CNT_W = 6;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESULT   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h14;

    // control register fields
    localparam int CTRL_START  = 0;
    localparam int CTRL_FORMAT = 1;
    localparam int CTRL_POL    = 2;
    localparam int CTRL_CONT   = 3;
    localparam int CTRL_STOP   = 4;

    // status register fields
    localparam int STAT_BUSY    = 0;
    localparam int STAT_CONV    = 1;
    localparam int STAT_VALID   = 2;
    localparam int STAT_R_FMT   = 8;
    localparam int STAT_R_POL   = 9;

    // interrupt fields
    localparam int IRQ_W       = 2;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_REFUSED = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;

    // ---------------------------------------------------------------
    // sequencer states, gray from S_IDLE through S_END along the usual path
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE    = 3'h0,
        S_SETUP   = 3'h1,
        S_PULSE   = 3'h3,
        S_WAIT_HI = 3'h2,
        S_WAIT_LO = 3'h6,
        S_READ    = 3'h7,
        S_END     = 3'h5,
        S_STOP    = 3'h4
    } state_t;

endpackage

// *** src/pin_sync.sv ***
// two-flop synchroniser for pins from the converter
module pin_sync
    import adc_host_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_clk_en,
    // pins
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else if (i_clk_en) begin
            meta   <= next_meta;
            o_sync <= next_sync;
        end
    end

endmodule // pin_sync

// *** src/axi_lite_slave.sv ***
// axi4-lite slave front end: turns bus transfers into register strobes
module axi_lite_slave
    import adc_host_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clk_en,
    // write address and data
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    // write response
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    // read
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // register side
    output logic                   o_wr_en,
    output logic [ADDR_W-1:0]      o_wr_addr,
    output logic [DATA_W-1:0]      o_wr_data,
    output logic [3:0]             o_wr_strb,
    output logic [ADDR_W-1:0]      o_rd_addr,
    input  wire logic [DATA_W-1:0] i_rd_data
);

    logic aw_held;
    logic w_held;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [DATA_W-1:0] next_wr_data;
    logic [3:0]        next_wr_strb;
    logic [DATA_W-1:0] next_rdata;

    assign o_awready = i_clk_en && !aw_held && !o_bvalid;
    assign o_wready  = i_clk_en && !w_held && !o_bvalid;
    assign o_arready = i_clk_en && !o_rvalid;
    assign o_wr_en   = i_clk_en && aw_held && w_held && !o_bvalid;
    assign o_rd_addr = i_araddr;
    assign o_bresp   = RESP_OKAY;
    assign o_rresp   = RESP_OKAY;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_wr_addr = o_wr_addr;
        next_wr_data = o_wr_data;
        next_wr_strb = o_wr_strb;
        next_bvalid  = o_bvalid;
        next_rvalid  = o_rvalid;
        next_rdata   = o_rdata;
        if (i_awvalid && o_awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            next_w_held  = 1'b1;
            next_wr_data = i_wdata;
            next_wr_strb = i_wstrb;
        end
        if (o_wr_en) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
        end else if (o_bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = i_rd_data;
        end else if (o_rvalid && i_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            o_wr_addr <= '0;
            o_wr_data <= '0;
            o_wr_strb <= '0;
            o_bvalid  <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
        end else if (i_clk_en) begin
            aw_held   <= next_aw_held;
            w_held    <= next_w_held;
            o_wr_addr <= next_wr_addr;
            o_wr_data <= next_wr_data;
            o_wr_strb <= next_wr_strb;
            o_bvalid  <= next_bvalid;
            o_rvalid  <= next_rvalid;
            o_rdata   <= next_rdata;
        end
    end

endmodule // axi_lite_slave

// *** src/adc_host_ctrl.sv ***
// host controller driving a bus-attached 8-bit converter's control pins
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
module adc_host_ctrl
    import adc_host_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_clk_en,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // converter pins
    output logic                   o_cs_n,
    output logic                   o_ce_n,
    output logic                   o_rw,
    output logic                   o_format,
    output logic                   o_polarity_select,
    input  wire logic              i_status,
    input  wire logic [7:0]        i_data,
    // interrupt
    output logic                   o_irq
);

    // ---------------------------------------------------------------
    // bus front end and pin synchronisers
    // ---------------------------------------------------------------
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0]        wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic              status_s;
    logic [7:0]        data_s;

    axi_lite_slave u_bus (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_clk_en  (i_clk_en),
        .i_awaddr  (i_awaddr),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .o_bresp   (o_bresp),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .i_araddr  (i_araddr),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .o_wr_en   (wr_en),
        .o_wr_addr (wr_addr),
        .o_wr_data (wr_data),
        .o_wr_strb (wr_strb),
        .o_rd_addr (rd_addr),
        .i_rd_data (rd_data)
    );

    pin_sync #(.W(9)) u_sync (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_clk_en (i_clk_en),
        .i_async  ({i_status, i_data}),
        .o_sync   ({status_s, data_s})
    );

    // ---------------------------------------------------------------
    // registers and sequencer state
    // ---------------------------------------------------------------
    state_t             state, next_state;
    logic [CNT_W-1:0]   cnt, next_cnt;
    logic               ctrl_format, next_ctrl_format;
    logic               ctrl_pol, next_ctrl_pol;
    logic               ctrl_cont, next_ctrl_cont;
    logic               start_req, next_start_req;
    logic               stop_req, next_stop_req;
    logic               cont_run, next_cont_run;
    logic               res_valid, next_res_valid;
    logic [7:0]         result, next_result;
    logic               res_format, next_res_format;
    logic               res_pol, next_res_pol;
    logic [IRQ_W-1:0]   irq_stat, next_irq_stat;
    logic [IRQ_W-1:0]   irq_en, next_irq_en;
    logic               next_cs_n, next_rw;
    logic               next_format, next_pol;
    logic               wr_ctrl;
    logic [IRQ_W-1:0]   irq_set;
    logic [IRQ_W-1:0]   irq_clr;

    assign wr_ctrl = wr_en && wr_strb[0] && (wr_addr == OFF_CTRL);
    assign o_ce_n  = o_cs_n;
    assign o_irq   = |(irq_stat & irq_en);

    always_comb begin
        rd_data = '0;
        unique case (rd_addr)
            OFF_CTRL: begin
                rd_data[CTRL_FORMAT] = ctrl_format;
                rd_data[CTRL_POL]    = ctrl_pol;
                rd_data[CTRL_CONT]   = ctrl_cont;
            end
            OFF_STATUS: begin
                rd_data[STAT_BUSY]  = (state != S_IDLE);
                rd_data[STAT_CONV]  = status_s;
                rd_data[STAT_VALID] = res_valid;
                rd_data[STAT_R_FMT] = res_format;
                rd_data[STAT_R_POL] = res_pol;
            end
            OFF_RESULT:   rd_data[7:0]       = result;
            OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat;
            OFF_IRQ_EN:   rd_data[IRQ_W-1:0] = irq_en;
            default:      rd_data = '0;
        endcase
    end

    always_comb begin
        next_state       = state;
        next_cnt         = cnt;
        next_ctrl_format = ctrl_format;
        next_ctrl_pol    = ctrl_pol;
        next_ctrl_cont   = ctrl_cont;
        next_start_req   = start_req;
        next_stop_req    = stop_req;
        next_cont_run    = cont_run;
        next_res_valid   = res_valid;
        next_result      = result;
        next_res_format  = res_format;
        next_res_pol     = res_pol;
        next_irq_en      = irq_en;
        next_cs_n        = o_cs_n;
        next_rw          = o_rw;
        next_format      = o_format;
        next_pol         = o_polarity_select;
        irq_set          = '0;
        irq_clr          = '0;
        if (wr_ctrl) begin
            // mode bits follow software at any time; the mode lines take them only at the next start
            next_ctrl_format = wr_data[CTRL_FORMAT];
            next_ctrl_pol    = wr_data[CTRL_POL];
            next_ctrl_cont   = wr_data[CTRL_CONT];
            if (wr_data[CTRL_STOP]) begin
                next_stop_req = 1'b1;
            end
            if (wr_data[CTRL_START]) begin
                if (state == S_IDLE && !start_req) begin
                    next_start_req = 1'b1;
                end else begin
                    irq_set[IRQ_REFUSED] = 1'b1;
                end
            end
        end
        if (wr_en && wr_strb[0] && wr_addr == OFF_IRQ_EN) begin
            next_irq_en = wr_data[IRQ_W-1:0];
        end
        if (wr_en && wr_strb[0] && wr_addr == OFF_IRQ_CLR) begin
            irq_clr = wr_data[IRQ_W-1:0];
        end
        if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
        unique case (state)
            S_IDLE: begin
                if (start_req) begin
                    // latch mode lines with rw low, ahead of the selects
                    next_format    = ctrl_format;
                    next_pol       = ctrl_pol;
                    next_cont_run  = ctrl_cont;
                    next_stop_req  = 1'b0;
                    next_start_req = 1'b0;
                    next_rw        = 1'b0;
                    next_cnt       = CNT_W'(T_DS_CYC);
                    next_state     = S_SETUP;
                end
            end
            S_SETUP: begin
                if (cnt == '0) begin
                    // both selects low with rw low is a convert
                    next_cs_n  = 1'b0;
                    next_cnt   = CNT_W'(T_W_CYC);
                    next_state = S_PULSE;
                end
            end
            S_PULSE: begin
                // hold the joint low time, then release the selects in single mode only
                if (cnt == '0) begin
                    if (!cont_run) begin
                        next_cs_n = 1'b1;
                    end
                    next_state = S_WAIT_HI;
                end
            end
            S_WAIT_HI: begin
                if (status_s) begin
                    next_state = cont_run ? S_STOP : S_WAIT_LO;
                end
            end
            S_STOP: begin
                // rw rises only while status is seen high
                if (stop_req && status_s) begin
                    next_rw       = 1'b1;
                    next_stop_req = 1'b0;
                    next_state    = S_WAIT_LO;
                end
            end
            S_WAIT_LO: begin
                // no new command until the cycle finishes
                if (!status_s) begin
                    next_rw    = 1'b1;
                    next_cs_n  = 1'b0;
                    next_cnt   = CNT_W'(T_RD_CYC);
                    next_state = S_READ;
                end
            end
            S_READ: begin
                // sample only after the access time has passed
                if (cnt == '0) begin
                    next_result     = data_s;
                    next_res_valid  = 1'b1;
                    next_res_format = o_format;
                    next_res_pol    = o_polarity_select;
                    next_cs_n       = 1'b1;
                    next_state      = S_END;
                end
            end
            S_END: begin
                irq_set[IRQ_DONE] = 1'b1;
                next_cont_run     = 1'b0;
                next_state        = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
        // sticky bits: a new event beats a clear in the same cycle
        next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state             <= S_IDLE;
            cnt               <= '0;
            ctrl_format       <= 1'b0;
            ctrl_pol          <= 1'b0;
            ctrl_cont         <= 1'b0;
            start_req         <= 1'b0;
            stop_req          <= 1'b0;
            cont_run          <= 1'b0;
            res_valid         <= 1'b0;
            result            <= 8'h00;
            res_format        <= 1'b0;
            res_pol           <= 1'b0;
            irq_stat          <= '0;
            irq_en            <= '0;
            o_cs_n            <= 1'b1;
            o_rw              <= 1'b1;
            o_format          <= 1'b0;
            o_polarity_select <= 1'b0;
        end else if (i_clk_en) begin
            state             <= next_state;
            cnt               <= next_cnt;
            ctrl_format       <= next_ctrl_format;
            ctrl_pol          <= next_ctrl_pol;
            ctrl_cont         <= next_ctrl_cont;
            start_req         <= next_start_req;
            stop_req          <= next_stop_req;
            cont_run          <= next_cont_run;
            res_valid         <= next_res_valid;
            result            <= next_result;
            res_format        <= next_res_format;
            res_pol           <= next_res_pol;
            irq_stat          <= next_irq_stat;
            irq_en            <= next_irq_en;
            o_cs_n            <= next_cs_n;
            o_rw              <= next_rw;
            o_format          <= next_format;
            o_polarity_select <= next_pol;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    int unsigned low_len;
    int unsigned rd_len;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            low_len <= 0;
            rd_len  <= 0;
        end else if (i_clk_en) begin
            low_len <= (!o_cs_n && !o_rw) ? low_len + 1 : 0;
            rd_len  <= (state == S_READ) ? rd_len + 1 : 0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_mode_stable: assert property (
        (!o_cs_n && !o_rw) |-> ($stable(o_format) && $stable(o_polarity_select)))
        else $error("mode lines moved during a convert command");
    a_mode_from_reg: assert property (
        (state == S_IDLE && start_req && i_clk_en)
        |=> (o_format == $past(ctrl_format) && o_polarity_select == $past(ctrl_pol)))
        else $error("mode lines do not follow the control register");
    a_start_pulse: assert property (
        (state == S_PULSE && $past(state) == S_SETUP) |-> (!o_cs_n && !o_ce_n && !o_rw))
        else $error("convert pulse not driven with all controls low");
    a_pulse_len: assert property (
        ($rose(o_cs_n) && !$past(o_rw)) |-> ($past(low_len) >= T_W_CYC - 1))
        else $error("convert pulse shorter than the least width");
    a_read_wait: assert property (
        (state == S_END && $past(state) == S_READ) |-> ($past(rd_len) >= T_RD_CYC))
        else $error("read data sampled too early");
    a_rw_rise: assert property (
        ($rose(o_rw) && $past(state) == S_STOP) |-> $past(status_s))
        else $error("rw raised while status was low");
    a_done_event: assert property (
        $rose(irq_stat[IRQ_DONE]) |-> $past(state) == S_END)
        else $error("done event without a finished read");

    c_single: cover property (state == S_END && !cont_run);
    c_cont: cover property (state == S_STOP ##[1:1000] state == S_WAIT_LO);
    c_refused: cover property ($rose(irq_stat[IRQ_REFUSED]));

endmodule // adc_host_ctrl

// *** test/adc_conv_model.sv ***
// behavioural model of the bus-attached converter
module adc_conv_model #(
    parameter int T_DC = 400,
    parameter int T_C  = 2000
) (
    input  wire logic              i_cs_n,
    input  wire logic              i_ce_n,
    input  wire logic              i_rw,
    input  wire logic              i_format,
    input  wire logic              i_polarity_select,
    input  wire logic signed [9:0] i_mv,
    output logic                   o_status,
    output logic [7:0]             o_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] res = 8'h00;
    logic       fmt;
    logic       pol;
    time        t_low = 0;
    wire        sel = !i_cs_n && !i_ce_n;
    initial o_status = 1'h0;
    always @(i_cs_n or i_ce_n or i_rw) t_low = $time;
    always begin
        wait (sel && !i_rw);
        #300;
        if (sel && !i_rw && $time - t_low >= 300) begin
            #(T_DC);
            o_status = 1'h1;
            fmt = i_format;
            pol = i_polarity_select;
            #(T_C);
            res = 8'(pol ? i_mv + 10'sd128 : i_mv) ^ {fmt, 7'h00};
            o_status = 1'h0;
        end
    end
    // result only in a read after conversion, its inverse at all other times
    assign #250 o_data = (sel && i_rw && !o_status) ? res : ~res;
endmodule // adc_conv_model

// *** test/adc_host_ctrl_tb.sv ***
// self-checking bench of the converter host controller
module adc_host_ctrl_tb
    import adc_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk = 1'h0, i_rst_n = 1'h0, i_clk_en = 1'h1;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00, i_data;
    logic [31:0] i_wdata = 32'h0, o_rdata, exp_q[$];
    logic [3:0]  i_wstrb = 4'hf;
    logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
    logic        i_arvalid = 1'h0, i_rready = 1'h0, i_status;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic        o_cs_n, o_ce_n, o_rw, o_format, o_polarity_select;
    logic [1:0]  o_bresp, o_rresp;
    logic signed [9:0] mv = 10'sh0;
    int          err_count = 0, samples_checked = 0, seed = 73676, rises = 0;
    adc_host_ctrl i_dut (.i_clk, .i_rst_n, .i_clk_en, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_cs_n, .o_ce_n,
        .o_rw, .o_format, .o_polarity_select, .i_status, .i_data, .o_irq);
    adc_conv_model i_conv (.i_cs_n(o_cs_n), .i_ce_n(o_ce_n), .i_rw(o_rw), .i_format(o_format),
        .i_polarity_select(o_polarity_select), .i_mv(mv), .o_status(i_status), .o_data(i_data));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_status) rises++;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    always @(posedge i_clk) begin
        if (o_rvalid === 1'h1 && i_rready === 1'h1) chk(o_rdata, exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        do begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'h0;
            if (o_wready) i_wvalid <= 1'h0;
        end while ((i_awvalid && !o_awready) || (i_wvalid && !o_wready));
        do @(posedge i_clk); while (o_bvalid !== 1'h1);
        i_bready <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        do @(posedge i_clk); while (o_arready !== 1'h1);
        i_arvalid <= 1'h0;
        do @(posedge i_clk); while (o_rvalid !== 1'h1);
        i_rready <= 1'h0;
        @(posedge i_clk);
    endtask
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'h1;
        @(posedge i_clk);
        chk(32'({o_cs_n, o_ce_n, o_rw, o_format, o_irq}), 32'h1c);
        rd(OFF_CTRL, 32'h0);
        rd(OFF_IRQ_STAT, 32'h0);
        rd(8'h40, 32'h0);
        $display("reset test done");
        wr(OFF_IRQ_EN, 32'h1);
        for (int m = 0; m < 4; m++) begin
            mv = m[1] ? 10'($random(seed) % 128) : 10'($random(seed) & 255);
            wr(OFF_CTRL, 32'(m * 2 + 1));
            wr(OFF_CTRL, 32'(m * 2 + 1));
            chk(32'(o_irq), 32'h0);
            if (m == 2) begin
                i_clk_en <= 1'h0;
                repeat (8) @(posedge i_clk);
                i_clk_en <= 1'h1;
            end
            while (o_irq !== 1'h1) @(posedge i_clk);
            rd(OFF_RESULT, 32'(8'(m[1] ? mv + 10'sd128 : mv) ^ {m[0], 7'h00}));
            rd(OFF_STATUS, 32'h4 | 32'(m) << 8);
            rd(OFF_IRQ_STAT, 32'h3);
            wr(OFF_IRQ_CLR, 32'h3);
            @(posedge i_clk);
            chk(32'(o_irq), 32'h0);
            chk(32'(rises), 32'(m + 1));
            $display("mode %0d done", m);
        end
        mv = 10'($random(seed) & 255);
        wr(OFF_CTRL, 32'h9);
        while (rises < 7) @(posedge i_clk);
        wr(OFF_CTRL, 32'h18);
        while (o_irq !== 1'h1) @(posedge i_clk);
        rd(OFF_RESULT, 32'(mv[7:0]));
        $display("continuous test done");
        finish_test();
    end
endmodule // adc_host_ctrl_tb
